// *** logic/sod_decoder.sv ***
`timescale 1ns/10ps
module sod_decoder
  import sod_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [2:0] sel,
  input wire logic timing_pulse_first,
  input wire logic timing_pulse_second,
  input wire logic unit_gate,
  output logic [7:0] dec_out,
  output logic gate_open
);

  sod_in_type in_now;
  logic [7:0] onehot;
  logic gate_q;
  logic gate_d;
  logic [7:0] out_d;
  logic [7:0] out_q;
  sod_gate_cmd_type cmd;

  assign in_now = '{sel: sel, timing_pulse_first: timing_pulse_first,
                    timing_pulse_second: timing_pulse_second, unit_gate: unit_gate};

  sod_onehot u_onehot (
    .sel(in_now.sel),
    .onehot(onehot)
  );

  function automatic sod_gate_cmd_type gate_cmd(input logic pa, input logic pb);
    if (pb) begin
      gate_cmd = SOD_GATE_OPEN;
    end else if (pa) begin
      gate_cmd = SOD_GATE_SHUT;
    end else begin
      gate_cmd = SOD_GATE_HOLD;
    end
  endfunction

  // gate latch per pulse levels
  always_comb begin
    cmd = gate_cmd(in_now.timing_pulse_first, in_now.timing_pulse_second);
    gate_d = gate_q;
    case (cmd)
      SOD_GATE_OPEN: gate_d = 1'b1;
      SOD_GATE_SHUT: gate_d = 1'b0;
      default: gate_d = gate_q;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_q <= SOD_GATE_RST;
    end else if (in_now.unit_gate) begin
      gate_q <= gate_d;
    end
  end

  // window from first pulse fall to second pulse fall
  always_comb begin
    if (in_now.unit_gate && !in_now.timing_pulse_first
        && (in_now.timing_pulse_second || !gate_d)) begin
      out_d = onehot;
    end else begin
      out_d = SOD_OUT_RST;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_q <= SOD_OUT_RST;
    end else begin
      out_q <= out_d;
    end
  end

  assign dec_out = out_q;
  assign gate_open = gate_q;

  // pulse steps seen by the checks
  sequence first_high_s;
    unit_gate && timing_pulse_first && !timing_pulse_second;
  endsequence

  sequence first_fall_s;
    first_high_s ##1 unit_gate && !timing_pulse_first && !timing_pulse_second;
  endsequence

  sequence second_high_s;
    unit_gate && !timing_pulse_first && timing_pulse_second;
  endsequence

  sequence second_fall_s;
    unit_gate && timing_pulse_second ##1 !timing_pulse_second;
  endsequence

  sequence window_idle_s;
    unit_gate && !timing_pulse_first && !timing_pulse_second && !gate_q;
  endsequence

  sequence shut_idle_s;
    unit_gate && !timing_pulse_first && !timing_pulse_second && gate_q;
  endsequence

  // outputs are checked one edge after the inputs they follow
  property onehot_out_p;
    @(posedge ref_clk) disable iff (!rst_b)
    $onehot0(dec_out);
  endproperty
  onehot_out_a: assert property (onehot_out_p) else $error("more than one output high");

  property gate_off_p;
    @(posedge ref_clk) disable iff (!rst_b)
    !unit_gate
    |=> dec_out == 8'h00;
  endproperty
  gate_off_a: assert property (gate_off_p) else $error("output high while gated off");

  property pick_sel_p;
    @(posedge ref_clk) disable iff (!rst_b)
    window_idle_s
    |=> dec_out == (8'h01 << $past(sel));
  endproperty
  pick_sel_a: assert property (pick_sel_p) else $error("wrong output selected");

  property one_high_p;
    @(posedge ref_clk) disable iff (!rst_b)
    window_idle_s
    |=> $onehot(dec_out);
  endproperty
  one_high_a: assert property (one_high_p) else $error("not one output in window");

  property latch_open_p;
    @(posedge ref_clk) disable iff (!rst_b)
    unit_gate && timing_pulse_second
    |=> gate_q;
  endproperty
  latch_open_a: assert property (latch_open_p) else $error("latch not set");

  property latch_shut_p;
    @(posedge ref_clk) disable iff (!rst_b)
    first_high_s
    |=> !gate_q;
  endproperty
  latch_shut_a: assert property (latch_shut_p) else $error("latch not cleared");

  property latch_hold_p;
    @(posedge ref_clk) disable iff (!rst_b)
    unit_gate && !timing_pulse_first && !timing_pulse_second
    |=> $stable(gate_q);
  endproperty
  latch_hold_a: assert property (latch_hold_p) else $error("latch changed while idle");

  property window_open_p;
    @(posedge ref_clk) disable iff (!rst_b)
    first_fall_s
    |=> $onehot(dec_out);
  endproperty
  window_open_a: assert property (window_open_p) else $error("no output in window");

  property no_glitch_p;
    @(posedge ref_clk) disable iff (!rst_b)
    timing_pulse_first
    |=> dec_out == 8'h00;
  endproperty
  no_glitch_a: assert property (no_glitch_p) else $error("output during first pulse");

  property second_end_p;
    @(posedge ref_clk) disable iff (!rst_b)
    second_fall_s
    |=> dec_out == 8'h00;
  endproperty
  second_end_a: assert property (second_end_p) else $error("output after second pulse");

  property second_hold_p;
    @(posedge ref_clk) disable iff (!rst_b)
    second_high_s
    |=> dec_out == (8'h01 << $past(sel));
  endproperty
  second_hold_a: assert property (second_hold_p) else $error("output lost early");

  property shut_quiet_p;
    @(posedge ref_clk) disable iff (!rst_b)
    shut_idle_s
    |=> dec_out == 8'h00;
  endproperty
  shut_quiet_a: assert property (shut_quiet_p) else $error("output outside window");

  property gate_freeze_p;
    @(posedge ref_clk) disable iff (!rst_b)
    !unit_gate
    |=> $stable(gate_q);
  endproperty
  gate_freeze_a: assert property (gate_freeze_p) else $error("latch moved gated off");

  property bit_code_p(int idx);
    @(posedge ref_clk) disable iff (!rst_b)
    dec_out[idx]
    |-> $past(sel) == 3'(idx);
  endproperty

  // each output only for its own code
  genvar b;
  generate
    for (b = 0; b < SOD_NUM_OUT; b++) begin : g_bit_chk
      bit_code_a: assert property (bit_code_p(b)) else $error("output off its code");
    end
  endgenerate

endmodule

// *** pkg/sod_pkg.sv ***
package sod_pkg;

  localparam int SOD_NUM_OUT = 8;
  localparam int SOD_SEL_W = 3;
  // latch starts open (1) so no output shows before a first pulse, except during a second pulse
  localparam logic SOD_GATE_RST = 1'b1;
  localparam logic [7:0] SOD_OUT_RST = 8'h00;
  localparam logic [1:0] SOD_EDGE_RST = 2'h0;

  typedef struct packed {
    logic [2:0] sel;
    logic timing_pulse_first;
    logic timing_pulse_second;
    logic unit_gate;
  } sod_in_type;

  typedef enum logic [1:0] {
    SOD_GATE_HOLD,
    SOD_GATE_OPEN,
    SOD_GATE_SHUT
  } sod_gate_cmd_type;

endpackage

// *** logic/sod_onehot.sv ***
`timescale 1ns/10ps
module sod_onehot
  import sod_pkg::*;
(
  input wire logic [2:0] sel,
  output logic [7:0] onehot
);

  genvar i;
  generate
    for (i = 0; i < SOD_NUM_OUT; i++) begin : g_dec
      assign onehot[i] = (sel == 3'(i));
    end
  endgenerate

endmodule

// *** dv/sod_cpu_model.sv ***
`timescale 1ns/10ps
module sod_cpu_model
  import sod_pkg::*;
(
  input wire logic ref_clk,
  output logic [2:0] sel,
  output logic timing_pulse_first,
  output logic timing_pulse_second,
  output logic memory_read_level
);
  initial begin
    sel = 3'h0;
    timing_pulse_first = 1'b0;
    timing_pulse_second = 1'b0;
    memory_read_level = 1'b0;
  end
  task automatic set_read(input logic lvl);
    @(negedge ref_clk) memory_read_level = lvl;
  endtask
  task automatic flip_sel();
    @(negedge ref_clk) sel = ~sel;
  endtask
  task automatic open_win(input logic [2:0] code);
    @(negedge ref_clk) sel = code;
    timing_pulse_first = 1'b1;
    @(negedge ref_clk) timing_pulse_first = 1'b0;
  endtask
  task automatic close_win();
    @(negedge ref_clk) timing_pulse_second = 1'b1;
    @(negedge ref_clk) timing_pulse_second = 1'b0;
    sel = ~sel;
  endtask
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/10ps
module testbench
  import sod_pkg::*;
;
  logic ref_clk, rst_b, unit_gate, tpf, tps, gate_open, mrl;
  logic [2:0] sel;
  logic [7:0] dec_out;
  int err_count = 0;
  int cmp_count = 0;
  sod_cpu_model cpu (.ref_clk(ref_clk), .sel(sel), .timing_pulse_first(tpf),
    .timing_pulse_second(tps), .memory_read_level(mrl));
  sod_decoder dut (.ref_clk(ref_clk), .rst_b(rst_b), .sel(sel), .timing_pulse_first(tpf),
    .timing_pulse_second(tps), .unit_gate(unit_gate), .dec_out(dec_out),
    .gate_open(gate_open));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d checks %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_codes();
    for (int i = 0; i < 8; i++) begin
      cpu.open_win(3'(i));
      repeat (2) @(negedge ref_clk);
      chk("dec_out", 8'h01 << i, dec_out);
      fork
        cpu.close_win();
        begin
          repeat (2) @(negedge ref_clk);
          chk("dec_out", 8'h01 << i, dec_out);
        end
      join
      repeat (2) @(negedge ref_clk);
      chk("dec_out", 8'h00, dec_out);
      chk("gate_open", 8'h01, {7'h00, gate_open});
    end
  endtask
  task automatic t_gate();
    cpu.open_win(3'h5);
    @(negedge ref_clk);
    chk("dec_out", 8'h20, dec_out);
    unit_gate = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("dec_out", 8'h00, dec_out);
    unit_gate = 1'b1;
    @(negedge ref_clk);
    chk("dec_out", 8'h20, dec_out);
    cpu.close_win();
  endtask
  task automatic t_glitch();
    cpu.open_win(3'h3);
    cpu.close_win();
    repeat (4) begin
      cpu.flip_sel();
      chk("dec_out", 8'h00, dec_out);
    end
  endtask
  task automatic t_ports();
    cpu.set_read(1'b1);
    cpu.open_win(3'h1);
    repeat (2) @(negedge ref_clk);
    chk("input_drive", 8'h02, dec_out & {8{mrl}});
    cpu.close_win();
    cpu.set_read(1'b0);
    cpu.open_win(3'h1);
    repeat (2) @(negedge ref_clk);
    chk("output_select", 8'h02, dec_out);
    chk("input_drive", 8'h00, dec_out & {8{mrl}});
    cpu.close_win();
    for (int c = 2; c < 8; c++) begin
      cpu.open_win(3'(c));
      repeat (2) @(negedge ref_clk);
      chk("expanded_port", 8'h01 << c, dec_out);
      cpu.close_win();
    end
  endtask
  task automatic t_addr();
    for (int blk = 0; blk < 16; blk++) begin
      @(negedge ref_clk) unit_gate = (blk < 8);
      cpu.open_win(3'(blk));
      repeat (2) @(negedge ref_clk);
      chk("addr_block", (blk < 8) ? 8'h01 << blk[2:0] : 8'h00, dec_out);
      cpu.close_win();
    end
    @(negedge ref_clk) unit_gate = 1'b1;
  endtask
  initial begin
    rst_b = 1'b0;
    unit_gate = 1'b1;
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    chk("dec_out", SOD_OUT_RST, dec_out);
    chk("gate_open", {7'h00, SOD_GATE_RST}, {7'h00, gate_open});
    repeat (2) @(negedge ref_clk);
    chk("dec_out", 8'h00, dec_out);
    t_codes();
    t_gate();
    t_glitch();
    t_ports();
    t_addr();
    tally_and_finish();
  end
  initial begin
    #40000;
    err_count++;
    tally_and_finish();
  end
endmodule
